/* src/fsp_ctrl.sv */
/*
  Self-programming controller: control register on classic Wishbone, command
  acceptance windows, section-busy tracking, CPU halt and the ready interrupt.
  Assumes the CPU core gives one-cycle store and load strobes on core_clk_i,
  and the flash array answers each erase or write with a one-cycle done.
*/
`timescale 1ns/1ps
// Function
// R1: Fuse one starts at address zero, fuse zero at the boot loader address.
// R2: Software has no path that changes any fuse value.
// R3: Ready interrupt is a level: enable and global flag set, store enable clear.
// R4: Erase or write to the readable section sets busy and blocks its reads.
// R5: Busy clears on re-enable after programming, or when a buffer load starts.
// R6: Bit five of the control register always reads zero.
// R7: Re-enable command with store within four cycles; refused while programming.
// R8: Writing re-enable during buffer loading discards the loaded data.
// R9: Lock command programs boot lock bits from R0; bit clears on finish or timeout.
// R10: Load within three cycles of lock command returns lock or fuse bits by Z0.
// R11: Write command writes the buffer to the page field; bit self-clears.
// R12: Erase command erases the page field's page; bit self-clears.
// R13: Programming the halt section halts the CPU for the whole operation.
// R14: Programming the readable section leaves the CPU running.
// R15: Enable alone stores R1:R0 into the buffer at the word field.
// R16: Store enable clears on store or timeout; stays set while programming.
// R17: Only five command patterns are accepted; others change nothing. The code still loads the interrupt enable, bit 7, on any control write.
// R18: The target page is latched when an operation starts.
// R19: Loads select bytes with Z0; buffer stores ignore Z0.
// R20: Software requests erase with pattern X0000011 then a store.
// R21: Software erases before writing, with the same page for both.
// R22: The buffer accepts words in any order.
// R23: Software loads a word with pattern 00000001 then a store.
// R24: Buffer clears after page write, on re-enable, and on reset.
// R25: Software requests write with pattern X0000101 then a store.
// R26: The window counts from the cycle the control write takes effect.
// R27: All control bits reset to zero.
module fsp_ctrl
  import fsp_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  spm_i,
  input  wire logic                  lpm_i,
  input  wire logic [15:0]           zptr_i,
  input  wire logic [15:0]           r1r0_i,
  input  wire logic                  gie_i,
  output logic      [7:0]            lpm_data_o,
  output logic                       lpm_hit_o,
  output logic                       cpu_halt_o,
  output logic                       rww_read_block_o,
  output logic                       ready_irq_o,
  output logic                       flash_erase_o,
  output logic                       flash_write_o,
  output logic      [FSP_PAGE_W-1:0] flash_page_o,
  input  wire logic                  flash_done_i,
  input  wire logic [FSP_WORD_W-1:0] flash_rd_idx_i,
  output logic      [FSP_DATA_W-1:0] flash_rd_data_o,
  output logic                       lock_prog_o,
  output logic      [3:0]            lock_prog_data_o,
  input  wire logic                  boot_reset_fuse_i,
  input  wire logic [7:0]            lock_bits_i,
  input  wire logic [7:0]            fuse_low_i,
  input  wire logic [7:0]            fuse_high_i,
  output logic      [11:0]           reset_vector_o
);
  typedef enum logic [2:0] {
    FSP_IDLE = 3'b001,
    FSP_ARMED = 3'b010,
    FSP_PROG = 3'b100
  } fsp_state_t;

  fsp_buf_if buf_if ();

  fsp_page_buf u_buf (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .bus        (buf_if.mem)
  );

  // Pin-side inputs pass two flops before use.
  logic [1:0]  fuse_sync_r;
  logic [7:0]  lock_s1_r, lock_s2_r, fl_s1_r, fl_s2_r, fh_s1_r, fh_s2_r;

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fuse_sync_r <= 2'h3;
      lock_s1_r   <= 8'hff;
      lock_s2_r   <= 8'hff;
      fl_s1_r     <= 8'hff;
      fl_s2_r     <= 8'hff;
      fh_s1_r     <= 8'hff;
      fh_s2_r     <= 8'hff;
    end
    else
    begin
      fuse_sync_r <= {fuse_sync_r[0], boot_reset_fuse_i};
      lock_s1_r   <= lock_bits_i;
      lock_s2_r   <= lock_s1_r;
      fl_s1_r     <= fuse_low_i;
      fl_s2_r     <= fl_s1_r;
      fh_s1_r     <= fuse_high_i;
      fh_s2_r     <= fh_s1_r;
    end
  end

  wire fuse_boot = fuse_sync_r[1];

  // The fuses are inputs only; no register write reaches them. [R2]
  assign reset_vector_o = fuse_boot ? FSP_APP_RESET_ADDR : FSP_BOOT_RESET_ADDR; // [R1]

  // Control state.
  fsp_state_t            state_r, state_nxt;
  logic                  irq_en_r;
  logic                  busy_r;
  logic [4:0]            cmd_r;
  logic [2:0]            win_r;
  logic                  halt_r;
  logic [FSP_PAGE_W-1:0] page_r;
  logic                  erase_r, write_r;
  logic                  ack_r;
  logic [7:0]            lpm_data_r;
  logic                  lpm_hit_r;
  logic                  lock_prog_r;
  logic [3:0]            lock_data_r;

  // Bus decode: a write takes effect on the edge where ack is seen high.
  wire       bus_req    = wb_cyc_i & wb_stb_i;
  wire       bus_wr     = bus_req & wb_we_i & ack_r;
  wire       sel_ctrl   = wb_adr_i == FSP_CTRL_OFS;
  wire       sel_status = wb_adr_i == FSP_STATUS_OFS;
  wire       ctrl_wr    = bus_wr & sel_ctrl & wb_sel_i[0];
  wire [4:0] wr_cmd     = wb_dat_i[4:0];
  wire       cmd_legal  = (wr_cmd == FSP_CMD_REEN) | (wr_cmd == FSP_CMD_LOCK) |
                          (wr_cmd == FSP_CMD_WRITE) | (wr_cmd == FSP_CMD_ERASE) |
                          (wr_cmd == FSP_CMD_LOAD); // [R17]
  wire       prog_busy  = state_r == FSP_PROG;
  wire       cmd_take   = ctrl_wr & cmd_legal & !prog_busy; // [R7] [R17]

  // Window: loaded on the write edge, so four later edges may take a store.
  wire       win_open   = (state_r == FSP_ARMED) & (win_r != 3'h0); // [R26]
  wire       lpm_open   = win_open & (win_r > (FSP_SPM_WIN - FSP_LPM_WIN)); // [R10]
  wire       spm_go     = win_open & spm_i;
  wire       do_load    = spm_go & (cmd_r == FSP_CMD_LOAD);
  wire       do_reen    = spm_go & (cmd_r == FSP_CMD_REEN);
  wire       do_lock    = spm_go & (cmd_r == FSP_CMD_LOCK);
  wire       do_prog    = spm_go & ((cmd_r == FSP_CMD_ERASE) | (cmd_r == FSP_CMD_WRITE));
  wire       do_read    = lpm_open & lpm_i & (cmd_r == FSP_CMD_LOCK) & !spm_i;
  wire       win_end    = (state_r == FSP_ARMED) & (win_r == 3'h1) & !spm_i & !do_read;
  wire       zpage_rww  = zptr_i[FSP_PAGE_W+FSP_WORD_W:FSP_WORD_W+1] < FSP_RWW_PAGES;

  // Lock and fuse read: Z0 picks lock bits over low fuses, Z1 the high fuses. [R10] [R19]
  wire [7:0] lock_sel   = zptr_i[0] ? lock_s2_r : fl_s2_r;
  wire [7:0] lpm_val    = zptr_i[1] ? fh_s2_r : lock_sel;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      FSP_IDLE:
        if (cmd_take)
          state_nxt = FSP_ARMED;
      FSP_ARMED:
        if (cmd_take)
          state_nxt = FSP_ARMED;
        else if (do_prog)
          state_nxt = FSP_PROG; // [R16]
        else if (spm_go || do_read || win_end)
          state_nxt = FSP_IDLE; // [R16]
      FSP_PROG:
        if (flash_done_i)
          state_nxt = FSP_IDLE;
      default:
        state_nxt = FSP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_r <= FSP_IDLE;
    else
      state_r <= state_nxt;
  end

  // Command bits stay set only while armed or programming; cleared on leaving.
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cmd_r <= FSP_CTRL_RST[4:0]; // [R27]
    else if (cmd_take)
      cmd_r <= wr_cmd;
    else if (state_nxt == FSP_IDLE)
      cmd_r <= 5'h00; // [R9] [R11] [R12] [R16]
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      win_r <= 3'h0;
    else if (cmd_take)
      win_r <= FSP_SPM_WIN; // [R26]
    else if (win_r != 3'h0)
      win_r <= win_r - 3'h1;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      irq_en_r <= FSP_CTRL_RST[FSP_IRQ_EN_BIT]; // [R27]
    else if (ctrl_wr)
      irq_en_r <= wb_dat_i[FSP_IRQ_EN_BIT];
  end

  // A new erase or write to the readable section sets busy, which wins over any clear in that cycle.
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      busy_r <= FSP_CTRL_RST[FSP_BUSY_BIT];
    else if (do_prog && zpage_rww)
      busy_r <= 1'b1; // [R4]
    else if (do_reen || do_load)
      busy_r <= 1'b0; // [R5] [R7]
  end

  // The page is latched at the start so the pointer is free afterwards.
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      page_r  <= '0;
      halt_r  <= 1'b0;
      erase_r <= 1'b0;
      write_r <= 1'b0;
    end
    else
    begin
      erase_r <= do_prog & (cmd_r == FSP_CMD_ERASE); // [R12]
      write_r <= do_prog & (cmd_r == FSP_CMD_WRITE); // [R11]
      if (do_prog)
      begin
        page_r <= zptr_i[FSP_PAGE_W+FSP_WORD_W:FSP_WORD_W+1]; // [R18]
        halt_r <= !zpage_rww; // [R13] [R14]
      end
      else if (flash_done_i)
        halt_r <= 1'b0;
    end
  end

  // Lock programming takes bits 5..2 of R0; the pointer and R1 are unused.
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lock_prog_r <= 1'b0;
      lock_data_r <= 4'hf;
    end
    else
    begin
      lock_prog_r <= do_lock; // [R9]
      if (do_lock)
        lock_data_r <= r1r0_i[5:2]; // [R9]
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lpm_data_r <= 8'h00;
      lpm_hit_r  <= 1'b0;
    end
    else
    begin
      lpm_hit_r <= do_read;
      if (do_read)
        lpm_data_r <= lpm_val; // [R10]
    end
  end

  // Buffer: stores drop Z0; re-enable, including mid-fill, empties the page.
  wire page_written = flash_done_i & (cmd_r == FSP_CMD_WRITE) & prog_busy;
  wire reen_written = cmd_take & (wr_cmd == FSP_CMD_REEN);

  assign buf_if.wr_en   = do_load; // [R15]
  assign buf_if.wr_idx  = zptr_i[FSP_WORD_W:1]; // [R19]
  assign buf_if.wr_data = r1r0_i; // [R15]
  assign buf_if.clr     = page_written | reen_written; // [R8] [R24]
  assign buf_if.rd_idx  = flash_rd_idx_i;

  // Store enable stays high throughout programming, so the interrupt waits too.
  wire store_enable_bit = state_r != FSP_IDLE; // [R16]

  assign ready_irq_o      = irq_en_r & gie_i & !store_enable_bit; // [R3]
  assign rww_read_block_o = busy_r; // [R4]
  assign cpu_halt_o       = halt_r & prog_busy; // [R13]

  // Reads return the live state; bit five is held at zero.
  wire [7:0] ctrl_rd = {irq_en_r, busy_r, 1'b0, cmd_r[4:1], store_enable_bit}; // [R6]
  wire [7:0] stat_rd = {5'h00, fuse_boot, halt_r, prog_busy};
  wire [7:0] rd_mux  = sel_ctrl ? ctrl_rd : (sel_status ? stat_rd : 8'h00);

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req & !ack_r;
  end

  logic [7:0] rdata_r;

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_r <= 8'h00;
    else if (bus_req && !ack_r)
      rdata_r <= rd_mux;
  end

  assign wb_ack_o         = ack_r;
  assign wb_dat_o         = {24'h000000, rdata_r};
  assign lpm_data_o       = lpm_data_r;
  assign lpm_hit_o        = lpm_hit_r;
  assign flash_erase_o    = erase_r;
  assign flash_write_o    = write_r;
  assign flash_page_o     = page_r;
  assign flash_rd_data_o  = buf_if.rd_data;
  assign lock_prog_o      = lock_prog_r;
  assign lock_prog_data_o = lock_data_r;
endmodule

/* src/fsp_pkg.sv */
/*
  Constants shared by the self-programming controller and its page buffer.
  Assumes a single 10 MHz core clock and a word-organised program flash.
*/
package fsp_pkg;
  // Register offsets on the Wishbone bus, byte addresses.
  localparam logic [3:0] FSP_CTRL_OFS   = 4'h0;
  localparam logic [3:0] FSP_STATUS_OFS = 4'h4;

  // Bit positions of the self_program_control register.
  localparam int FSP_IRQ_EN_BIT  = 7;
  localparam int FSP_BUSY_BIT    = 6;
  localparam int FSP_RSVD_BIT    = 5;
  localparam int FSP_REEN_BIT    = 4;
  localparam int FSP_LOCK_BIT    = 3;
  localparam int FSP_PAGE_WRITE_BIT_BIT   = 2;
  localparam int FSP_PAGE_ERASE_BIT_BIT   = 1;
  localparam int FSP_STORE_ENABLE_BIT_BIT   = 0;

  // Bit positions of the status register.
  localparam int FSP_ST_OP_BIT   = 0;
  localparam int FSP_ST_HALT_BIT = 1;
  localparam int FSP_ST_FUSE_BIT = 2;

  localparam logic [7:0] FSP_CTRL_RST = 8'h00;

  // Accepted low five-bit command patterns.
  localparam logic [4:0] FSP_CMD_REEN  = 5'h11;
  localparam logic [4:0] FSP_CMD_LOCK  = 5'h09;
  localparam logic [4:0] FSP_CMD_WRITE = 5'h05;
  localparam logic [4:0] FSP_CMD_ERASE = 5'h03;
  localparam logic [4:0] FSP_CMD_LOAD  = 5'h01;

  // Acceptance windows in core clock cycles.
  localparam logic [2:0] FSP_SPM_WIN = 3'h4;
  localparam logic [2:0] FSP_LPM_WIN = 3'h3;

  // Flash geometry: 32-word pages, 128 pages.
  localparam int FSP_WORD_W = 5;
  localparam int FSP_PAGE_W = 7;
  localparam int FSP_DATA_W = 16;
  localparam int FSP_DEPTH  = 32;
  localparam logic [FSP_PAGE_W-1:0] FSP_RWW_PAGES = 7'h60;

  localparam logic [11:0] FSP_APP_RESET_ADDR  = 12'h000;
  localparam logic [11:0] FSP_BOOT_RESET_ADDR = 12'hc00;

  localparam logic [FSP_DATA_W-1:0] FSP_ERASED_WORD = 16'hffff;
endpackage

/* src/fsp_buf_if.sv */
/*
  Carrier between the controller and its temporary page buffer.
  Assumes both ends share the core clock.
*/
`timescale 1ns/1ps
interface fsp_buf_if;
  import fsp_pkg::*;
  logic                  wr_en;
  logic [FSP_WORD_W-1:0] wr_idx;
  logic [FSP_DATA_W-1:0] wr_data;
  logic                  clr;
  logic [FSP_WORD_W-1:0] rd_idx;
  logic [FSP_DATA_W-1:0] rd_data;

  modport ctl (output wr_en, output wr_idx, output wr_data, output clr,
               output rd_idx, input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data, input clr,
               input rd_idx, output rd_data);
endinterface

/* src/fsp_page_buf.sv */
/*
  Temporary page buffer: one page of words with a fill mark per entry.
  Assumes the controller drives the ctl side on the same clock.
*/
`timescale 1ns/1ps
module fsp_page_buf
  import fsp_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  fsp_buf_if.mem    bus
);
  logic [FSP_DATA_W-1:0] mem_r [FSP_DEPTH];
  logic [FSP_DEPTH-1:0]  filled_r;
  logic [FSP_DATA_W-1:0] rd_data_r;
  wire                   slot_free = ~filled_r[bus.wr_idx];

  // A word can be placed once per fill; the entries take any order. [R22]
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      filled_r <= '0;
    else if (bus.clr)
      filled_r <= '0;
    else if (bus.wr_en && slot_free)
      filled_r[bus.wr_idx] <= 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (bus.wr_en && slot_free && !bus.clr)
      mem_r[bus.wr_idx] <= bus.wr_data;
  end

  // Entries never filled read as erased flash.
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rd_data_r <= FSP_ERASED_WORD;
    else if (filled_r[bus.rd_idx])
      rd_data_r <= mem_r[bus.rd_idx];
    else
      rd_data_r <= FSP_ERASED_WORD;
  end

  assign bus.rd_data = rd_data_r;
endmodule

/* testbench/fsp_ctrl_assertions.sv */
/*
  Port checker for the self-programming controller, bound to fsp_ctrl.
  Assumes one core clock and a flash array that ends each operation with a done pulse.
*/
`timescale 1ns/1ps
module fsp_ctrl_assertions
  import fsp_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        spm_i,
  input wire logic        lpm_i,
  input wire logic [15:0] zptr_i,
  input wire logic [15:0] r1r0_i,
  input wire logic        gie_i,
  input wire logic        lpm_hit_o,
  input wire logic        cpu_halt_o,
  input wire logic        rww_read_block_o,
  input wire logic        ready_irq_o,
  input wire logic        flash_erase_o,
  input wire logic        flash_write_o,
  input wire logic [6:0]  flash_page_o,
  input wire logic        flash_done_i,
  input wire logic        lock_prog_o,
  input wire logic [3:0]  lock_prog_data_o,
  input wire logic        boot_reset_fuse_i,
  input wire logic [11:0] reset_vector_o
);
  wire logic       start_w  = flash_erase_o || flash_write_o;
  wire logic [6:0] zpage_w  = zptr_i[12:6];
  wire logic [3:0] r0bits_w = r1r0_i[5:2];
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // The synchroniser resets to one and needs two edges, so three steady samples suffice; the checks wait for four.
  AST_VEC_APP:
    assert property (boot_reset_fuse_i [*4] |-> reset_vector_o == FSP_APP_RESET_ADDR)
    else $error("reset vector is not the application address");
  AST_VEC_BOOT:
    assert property (!boot_reset_fuse_i [*4] |-> reset_vector_o == FSP_BOOT_RESET_ADDR)
    else $error("reset vector is not the boot address");
  AST_HALT_SET:
    assert property (start_w && flash_page_o >= FSP_RWW_PAGES |-> cpu_halt_o)
    else $error("halt missing for halt-section page");
  AST_RWW_RUN:
    assert property (start_w && flash_page_o < FSP_RWW_PAGES |-> !cpu_halt_o && rww_read_block_o)
    else $error("readable-section operation halted cpu or left busy clear");
  AST_HALT_HOLD:
    assert property (cpu_halt_o && !flash_done_i |=> cpu_halt_o)
    else $error("halt dropped before done");
  AST_IRQ:
    assert property (ready_irq_o |-> gie_i && !cpu_halt_o && !start_w)
    else $error("ready interrupt while disabled or busy");
  AST_PAGE_CAPT:
    assert property (start_w |-> flash_page_o == $past(zpage_w))
    else $error("page not taken from pointer");
  AST_PAGE_HOLD:
    assert property (start_w |=> $stable(flash_page_o) [*2])
    else $error("latched page changed");
  AST_LOCK_PROG:
    assert property (lock_prog_o |-> $past(spm_i) && lock_prog_data_o == $past(r0bits_w))
    else $error("lock programming data wrong");
  AST_LPM_HIT:
    assert property (lpm_hit_o |-> $past(lpm_i))
    else $error("special load answer without load");
  AST_RSVD:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i == FSP_CTRL_OFS |-> !wb_dat_o[FSP_RSVD_BIT])
    else $error("reserved bit reads one");
  AST_ONE_PULSE:
    assert property (start_w |=> !start_w)
    else $error("start pulse longer than one cycle");
  cover property (cpu_halt_o && flash_done_i);
  cover property (lpm_hit_o);
  cover property (lock_prog_o);
endmodule

bind fsp_ctrl fsp_ctrl_assertions fsp_ctrl_assertions_inst (.core_clk_i, .resetn_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .spm_i, .lpm_i, .zptr_i, .r1r0_i, .gie_i, .lpm_hit_o,
  .cpu_halt_o, .rww_read_block_o, .ready_irq_o, .flash_erase_o, .flash_write_o, .flash_page_o,
  .flash_done_i, .lock_prog_o, .lock_prog_data_o, .boot_reset_fuse_i, .reset_vector_o);

/* testbench/fsp_cpu_model.sv */
/*
  CPU core and flash array stand-in: one-cycle store and load strobes on request,
  and a done pulse a set number of cycles after each erase or write starts.
*/
`timescale 1ns/1ps
module fsp_cpu_model
(
  input  wire logic        core_clk_i,
  input  wire logic        flash_start_i,
  input  wire logic [7:0]  dly_i,
  output logic             spm_o        = 1'b0,
  output logic             lpm_o        = 1'b0,
  output logic      [15:0] zptr_o       = 16'h0000,
  output logic      [15:0] r1r0_o       = 16'h0000,
  output logic             flash_done_o = 1'b0
);
  logic [7:0] cnt_r = 8'h00;
  // Released lines show the inverse value, so a stale pointer is never taken as fresh.
  task automatic issue(input logic ld, input logic [15:0] z, input logic [15:0] d);
    spm_o  <= !ld;
    lpm_o  <= ld;
    zptr_o <= z;
    r1r0_o <= d;
    @(posedge core_clk_i);
    spm_o  <= 1'b0;
    lpm_o  <= 1'b0;
    zptr_o <= ~z;
    r1r0_o <= ~d;
  endtask
  always @(posedge core_clk_i)
  begin
    flash_done_o <= (cnt_r == 8'h01);
    if (flash_start_i)
      cnt_r <= dly_i;
    else if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
  end
endmodule

/* testbench/test_flash_self_program_control.sv */
/*
  Self-checking bench for the self-programming controller.
  Assumes Wishbone answers come one cycle after a request and the stand-in drives the CPU side.
*/
`timescale 1ns/1ps
module test_flash_self_program_control
  import fsp_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [3:0]  adr      = 4'h0;
  logic [3:0]  sel      = 4'h0;
  logic [31:0] wdat     = 32'h0;
  logic        gie      = 1'b1;
  logic [4:0]  rd_idx   = 5'h00;
  logic        fuse     = 1'b1;
  logic [7:0]  dly      = 8'h14;
  logic [7:0]  rq;
  logic [31:0] rdat;
  logic [15:0] rd_data;
  logic [15:0] zptr;
  logic [15:0] r1r0;
  logic [7:0]  lpm_data;
  logic [6:0]  fpage;
  logic [3:0]  lprog_d;
  logic [11:0] rvec;
  logic        ack, program_store_instruction, lpm, lpm_hit, halt, busy, irq, ferase, fwrite, fdone, lprog;
  int          err_count   = 0;
  int          comparisons = 0;
  logic [7:0]  bad [5]  = '{8'h3f, 8'h07, 8'h13, 8'h0b, 8'h20};
  logic [15:0] zsel [3] = '{16'h0001, 16'h0000, 16'h0003};
  logic [7:0]  pins [3] = '{8'hc5, 8'h3a, 8'h9c};

  fsp_ctrl fsp_ctrl_inst (
    .core_clk_i(core_clk), .resetn_i(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .spm_i(program_store_instruction), .lpm_i(lpm), .zptr_i(zptr), .r1r0_i(r1r0), .gie_i(gie), .lpm_data_o(lpm_data),
    .lpm_hit_o(lpm_hit), .cpu_halt_o(halt), .rww_read_block_o(busy), .ready_irq_o(irq),
    .flash_erase_o(ferase), .flash_write_o(fwrite), .flash_page_o(fpage), .flash_done_i(fdone),
    .flash_rd_idx_i(rd_idx), .flash_rd_data_o(rd_data), .lock_prog_o(lprog),
    .lock_prog_data_o(lprog_d), .boot_reset_fuse_i(fuse), .lock_bits_i(8'hc5),
    .fuse_low_i(8'h3a), .fuse_high_i(8'h9c), .reset_vector_o(rvec));
  fsp_cpu_model fsp_cpu_model_inst (.core_clk_i(core_clk), .flash_start_i(ferase | fwrite),
    .dly_i(dly), .spm_o(program_store_instruction), .lpm_o(lpm), .zptr_o(zptr), .r1r0_o(r1r0), .flash_done_o(fdone));

  always #50 core_clk = ~core_clk;

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic hang(input string nm);
    err_count++;
    $display("BAD %s expected answer seen timeout", nm);
    summarize();
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // The request is held until ack is sampled; read data is taken at that same edge.
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'h1;
    wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1)
      hang("bus ack");
    rq = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(nm, rq, e);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] z, input logic [15:0] d);
    wb(1'b1, FSP_CTRL_OFS, c);
    fsp_cpu_model_inst.issue(1'b0, z, d);
  endtask
  task automatic buf_chk(input logic [4:0] i, input logic [15:0] e);
    @(posedge core_clk);
    rd_idx <= i;
    repeat (2) @(posedge core_clk);
    chk("buffer word", rd_data, e);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      wb(1'b0, FSP_CTRL_OFS, 8'h00);
      n++;
    end
    while (rq[0] !== 1'b0 && n < 40);
    if (rq[0] !== 1'b0)
      hang("store enable clear");
  endtask

  initial
  begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    rd_chk("ctrl reset", FSP_CTRL_OFS, 8'h00);
    wb(1'b1, FSP_STATUS_OFS, 8'hff);
    wb(1'b1, 4'h8, 8'hff);
    rd_chk("unmapped", 4'h8, 8'h00);
    chk("reset vector", rvec, FSP_APP_RESET_ADDR);
    foreach (bad[i])
    begin
      wb(1'b1, FSP_CTRL_OFS, bad[i]);
      rd_chk("illegal command", FSP_CTRL_OFS, 8'h00);
    end
    wb(1'b1, FSP_CTRL_OFS, 8'h81);
    repeat (5) @(posedge core_clk);
    rd_chk("enable timeout", FSP_CTRL_OFS, 8'h80);
    chk("ready irq", irq, 1'b1);
    fsp_cpu_model_inst.issue(1'b0, 16'h0012, 16'h1111);
    buf_chk(5'h09, FSP_ERASED_WORD);
    cmd(8'h81, 16'h003f, 16'h1234);
    cmd(8'h81, 16'h0002, 16'habcd);
    buf_chk(5'h1f, 16'h1234);
    buf_chk(5'h01, 16'habcd);
    cmd(8'h91, 16'h0000, 16'h0000);
    buf_chk(5'h1f, FSP_ERASED_WORD);
    cmd(8'h81, 16'h0146, 16'h5a5a);
    cmd(8'h83, 16'h0140, 16'h0000);
    @(posedge core_clk);
    chk("halt", halt, 1'b0);
    chk("busy", busy, 1'b1);
    chk("page", fpage, 7'h05);
    chk("irq in op", irq, 1'b0);
    rd_chk("ctrl in op", FSP_CTRL_OFS, 8'hc3);
    rd_chk("status in op", FSP_STATUS_OFS, 8'h05);
    wb(1'b1, FSP_CTRL_OFS, 8'h91);
    wait_idle();
    chk("after erase", rq, 8'hc0);
    chk("ready irq", irq, 1'b1);
    cmd(8'h85, 16'h0140, 16'h0000);
    wait_idle();
    chk("after write", rq, 8'hc0);
    buf_chk(5'h03, FSP_ERASED_WORD);
    cmd(8'h91, 16'h0000, 16'h0000);
    rd_chk("reenabled", FSP_CTRL_OFS, 8'h80);
    dly <= 8'h03;
    cmd(8'h83, 16'h1c00, 16'h0000);
    @(posedge core_clk);
    chk("halt", halt, 1'b1);
    chk("page", fpage, 7'h70);
    rd_chk("status halt", FSP_STATUS_OFS, 8'h07);
    wait_idle();
    chk("halt end", halt, 1'b0);
    cmd(8'h83, 16'h0080, 16'h0000);
    wait_idle();
    chk("busy", busy, 1'b1);
    cmd(8'h81, 16'h0004, 16'h7777);
    @(posedge core_clk);
    chk("busy on load", busy, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, FSP_CTRL_OFS, 8'h89);
      fsp_cpu_model_inst.issue(1'b1, zsel[i], 16'h0000);
      @(posedge core_clk);
      chk("special load", {lpm_hit, lpm_data}, {1'b1, pins[i]});
    end
    cmd(8'h89, 16'h0001, 16'hffd7);
    @(posedge core_clk);
    chk("lock program", {lprog, lprog_d}, 5'h15);
    rd_chk("lock clear", FSP_CTRL_OFS, 8'h80);
    fuse <= 1'b0;
    gie  <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("boot vector", rvec, FSP_BOOT_RESET_ADDR);
    chk("irq off", irq, 1'b0);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rd_chk("ctrl reset", FSP_CTRL_OFS, 8'h00);
    summarize();
  end
endmodule
